// ==== src/regulator_interrupt_masks.sv ====
// Interrupt masking for two step-down converters and the register reset
// event. Assumes reg_* strobes come from a byte-wide serial front end,
// raw status inputs are synchronous to clk_sys.
//
// Overview of operation
// [R1] Top mask bit 0 gates the register-reset interrupt; 1 suppresses; default 1.
// [R2] Host writes to that bit do not stick; it reloads on reset.
// [R3] Converter mask bit 7 suppresses converter 1 power-good invalid interrupt.
// [R4] Bit 6 suppresses converter 1 power-good valid interrupt; default 1.
// [R5] Bit 4 suppresses converter 1 current-limit interrupt; default 0.
// [R6] Bit 3 suppresses converter 0 power-good invalid interrupt; default 1.
// [R7] Bit 2 suppresses converter 0 power-good valid interrupt; default 1.
// [R8] Bit 0 suppresses converter 0 current-limit interrupt; default 0.
// [R9] Raw status bits update regardless of masks.
// [R10] Converter mask bits 5 and 1 are reserved, read as zero.
// [R11] Flags set only for unmasked transition direction or current-limit.
`timescale 1ns/1ps
`default_nettype none
module regulator_interrupt_masks
  import irq_mask_pkg::*;
#(
  parameter logic RESET_GATE_OTP = RESET_GATE_DEF
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Register port
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output var  logic [7:0] reg_rdata,
  // Raw converter status
  input  wire logic       conv0_pg_in,
  input  wire logic       conv1_pg_in,
  input  wire logic       conv0_overcurrent_in,
  input  wire logic       conv1_overcurrent_in,
  input  wire logic       reset_reg_event,
  // Flag clears, one pulse per flag
  input  wire logic       conv0_pg_irq_clr,
  input  wire logic       conv1_pg_irq_clr,
  input  wire logic       conv0_overcurrent_irq_clr,
  input  wire logic       conv1_overcurrent_irq_clr,
  input  wire logic       reset_reg_irq_clr,
  // Status and flags
  output var  logic       conv0_pg_raw,
  output var  logic       conv1_pg_raw,
  output var  logic       conv0_overcurrent_raw,
  output var  logic       conv1_overcurrent_raw,
  output var  logic       conv0_pg_irq_flag,
  output var  logic       conv1_pg_irq_flag,
  output var  logic       conv0_overcurrent_irq_flag,
  output var  logic       conv1_overcurrent_irq_flag,
  output var  logic       reset_reg_irq_flag
);

  // ****************************************************************
  // Mask registers
  // ****************************************************************
  logic [7:0] conv_mask_ff;
  logic [7:0] nxt_conv_mask;
  logic       reset_gate_ff;
  logic       nxt_reset_gate;
  logic [7:0] nxt_rdata;

  // Reserved bits never store; reset gate ignores host writes
  always_comb begin
    nxt_conv_mask  = conv_mask_ff;
    nxt_reset_gate = reset_gate_ff;  // [R2]
    if (reg_wr && reg_addr == ADDR_CONV_MASK) begin
      nxt_conv_mask = reg_wdata & CONV_MASK_WMASK;  // [R10]
    end
  end

  // Read data is registered; unmapped addresses read zero
  always_comb begin
    nxt_rdata = reg_rdata;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_TOP_MASK_TWO: nxt_rdata = {7'h00, reset_gate_ff};
        ADDR_CONV_MASK:    nxt_rdata = conv_mask_ff;  // [R10]
        default:           nxt_rdata = ZERO_BYTE;
      endcase
    end
  end

  // Reset gate comes from the fused value, a constant under reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      conv_mask_ff  <= CONV_MASK_RESET;  // [R4] [R5] [R6] [R7] [R8]
      reset_gate_ff <= RESET_GATE_OTP;  // [R1] [R2]
      reg_rdata     <= ZERO_BYTE;
    end else begin
      conv_mask_ff  <= nxt_conv_mask;
      reset_gate_ff <= nxt_reset_gate;
      reg_rdata     <= nxt_rdata;
    end
  end

  // ****************************************************************
  // Raw status and event flags
  // ****************************************************************
  logic [3:0] raw_ff;
  logic [3:0] nxt_raw;
  logic [3:0] raw_in;
  logic [3:0] flag_ff;
  logic [3:0] nxt_flag;
  logic [3:0] clr_in;
  logic [3:0] set_ev;
  logic       rr_flag_ff;
  logic       nxt_rr_flag;

  // Index order: c0 pg, c1 pg, c0 overcurrent, c1 overcurrent
  assign raw_in = {conv1_overcurrent_in, conv0_overcurrent_in,
                   conv1_pg_in, conv0_pg_in};
  assign clr_in = {conv1_overcurrent_irq_clr, conv0_overcurrent_irq_clr,
                   conv1_pg_irq_clr, conv0_pg_irq_clr};

  // Raw bit 1 means output invalid, so a rise is the fall of validity
  always_comb begin
    nxt_raw = raw_in;  // [R9]
    set_ev[0] = (raw_in[0] & ~raw_ff[0] & ~conv_mask_ff[BIT_C0_PG_FALL])
              | (~raw_in[0] & raw_ff[0] & ~conv_mask_ff[BIT_C0_PG_RISE]);
    set_ev[1] = (raw_in[1] & ~raw_ff[1] & ~conv_mask_ff[BIT_C1_PG_FALL])
              | (~raw_in[1] & raw_ff[1] & ~conv_mask_ff[BIT_C1_PG_RISE]);
    set_ev[2] = raw_in[2] & ~raw_ff[2] & ~conv_mask_ff[BIT_C0_OC];  // [R8]
    set_ev[3] = raw_in[3] & ~raw_ff[3] & ~conv_mask_ff[BIT_C1_OC];  // [R5]
    // Set beats clear so a coincident event is never lost
    nxt_flag    = set_ev | (flag_ff & ~clr_in);  // [R11] [R3] [R6] [R4] [R7]
    nxt_rr_flag = (reset_reg_event & ~reset_gate_ff)
                | (rr_flag_ff & ~reset_reg_irq_clr);  // [R1]
  end

  // Raw starts at zero: an input already high when reset ends reads as a rise in the first cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      raw_ff     <= 4'h0;
      flag_ff    <= 4'h0;
      rr_flag_ff <= 1'h0;
    end else begin
      raw_ff     <= nxt_raw;
      flag_ff    <= nxt_flag;
      rr_flag_ff <= nxt_rr_flag;
    end
  end

  assign conv0_pg_raw               = raw_ff[0];
  assign conv1_pg_raw               = raw_ff[1];
  assign conv0_overcurrent_raw      = raw_ff[2];
  assign conv1_overcurrent_raw      = raw_ff[3];
  assign conv0_pg_irq_flag          = flag_ff[0];
  assign conv1_pg_irq_flag          = flag_ff[1];
  assign conv0_overcurrent_irq_flag = flag_ff[2];
  assign conv1_overcurrent_irq_flag = flag_ff[3];
  assign reset_reg_irq_flag         = rr_flag_ff;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_RR_MASKED: assert property ( // [R1]
    reset_gate_ff && !rr_flag_ff |=> !rr_flag_ff)
    else $error("reset-reg flag set while masked");
  AST_RR_GATE_HOLD: assert property ( // [R2]
    ##1 $stable(reset_gate_ff))
    else $error("reset gate changed outside reset");
  AST_C1_FALL: assert property ( // [R3]
    !conv_mask_ff[BIT_C1_PG_FALL] && !raw_ff[1] && conv1_pg_in
    |=> conv1_pg_irq_flag)
    else $error("c1 invalid event lost");
  AST_C1_RISE_MASK: assert property ( // [R4]
    conv_mask_ff[BIT_C1_PG_RISE] && raw_ff[1] && !conv1_pg_in
    && !conv1_pg_irq_flag && conv_mask_ff[BIT_C1_PG_FALL]
    |=> !conv1_pg_irq_flag)
    else $error("c1 valid event not masked");
  // The gate that decided the edge is the one of the cycle before
  AST_C1_OC: assert property ( // [R5]
    $rose(conv1_overcurrent_raw) && !$past(conv_mask_ff[BIT_C1_OC])
    |-> conv1_overcurrent_irq_flag)
    else $error("c1 overcurrent flag missing");
  AST_C0_FALL: assert property ( // [R6]
    !conv_mask_ff[BIT_C0_PG_FALL] && !raw_ff[0] && conv0_pg_in
    |=> conv0_pg_irq_flag)
    else $error("c0 invalid event lost");
  AST_C0_RISE: assert property ( // [R7]
    !conv_mask_ff[BIT_C0_PG_RISE] && raw_ff[0] && !conv0_pg_in
    |=> conv0_pg_irq_flag)
    else $error("c0 valid event lost");
  AST_C0_OC_MASK: assert property ( // [R8]
    conv_mask_ff[BIT_C0_OC] && !conv0_overcurrent_irq_flag
    |=> !conv0_overcurrent_irq_flag)
    else $error("c0 overcurrent not masked");
  AST_RAW_TRACK: assert property ( // [R9]
    ##1 conv0_pg_raw == $past(conv0_pg_in))
    else $error("raw status not tracking");
  AST_RSVD: assert property ( // [R10]
    conv_mask_ff[5] == 1'b0 && conv_mask_ff[1] == 1'b0)
    else $error("reserved bits nonzero");

  // Positive sides, plus the closed c0 invalid gate: an open gate must let its event through, a closed one must not
  AST_RR_SET: assert property ( // [R1]
    reset_reg_event && !reset_gate_ff |=> reset_reg_irq_flag)
    else $error("reset-reg event lost with gate open");
  AST_C1_RISE: assert property ( // [R4]
    !conv_mask_ff[BIT_C1_PG_RISE] && raw_ff[1] && !conv1_pg_in
    |=> conv1_pg_irq_flag)
    else $error("c1 valid event lost");
  AST_C0_FALL_MASK: assert property ( // [R6]
    conv_mask_ff[BIT_C0_PG_FALL] && !raw_ff[0] && conv0_pg_in
    && !conv0_pg_irq_flag |=> !conv0_pg_irq_flag)
    else $error("c0 invalid event not masked");
  AST_C0_OC_SET: assert property ( // [R8]
    !conv_mask_ff[BIT_C0_OC] && !raw_ff[2] && conv0_overcurrent_in
    |=> conv0_overcurrent_irq_flag)
    else $error("c0 overcurrent event lost");
  // A clear with no new edge in the same cycle must empty the flag
  AST_OC_CLR: assert property ( // [R11]
    conv1_overcurrent_irq_flag && conv1_overcurrent_irq_clr
    && !(conv1_overcurrent_in && !raw_ff[3])
    |=> !conv1_overcurrent_irq_flag)
    else $error("c1 overcurrent flag not cleared");

  COV_C0_PG: cover property ($rose(conv0_pg_irq_flag));
  COV_C1_OC: cover property ($rose(conv1_overcurrent_irq_flag));
  COV_MASK_WR: cover property (reg_wr && reg_addr == ADDR_CONV_MASK);
  COV_RR: cover property ($rose(reset_reg_irq_flag));

endmodule // regulator_interrupt_masks
`default_nettype wire

// ==== src/irq_mask_pkg.sv ====
// Constants for the converter interrupt mask block.
// Assumes a byte-wide register port decoded by the serial front end.
package irq_mask_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ADDR_TOP_MASK_TWO  = 8'h21;
  localparam logic [7:0] ADDR_CONV_MASK     = 8'h22;
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_RESET_REG_GATE  = 0;
  localparam int BIT_C1_PG_FALL      = 7;
  localparam int BIT_C1_PG_RISE      = 6;
  localparam int BIT_C1_OC           = 4;
  localparam int BIT_C0_PG_FALL      = 3;
  localparam int BIT_C0_PG_RISE      = 2;
  localparam int BIT_C0_OC           = 0;
  // Writable bits of the converter mask; 5 and 1 are reserved zero
  localparam logic [7:0] CONV_MASK_WMASK = 8'hDD;
  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] CONV_MASK_RESET = 8'hCC;
  localparam logic       RESET_GATE_DEF  = 1'h1;
  localparam logic [7:0] ZERO_BYTE       = 8'h00;
  // Register port answer states, gray along the path
  typedef enum logic [1:0] {
    PORT_IDLE_type = 2'h0,
    PORT_RESP_type = 2'h1
  } port_state_type;
endpackage

// ==== sim/converter_far_side.sv ====
// Model of the two converters that feed the mask block.
// Assumes the bench asks for levels; clk_sys runs at 40 MHz.
`timescale 1ns/1ps
`default_nettype none
module converter_far_side (
  // Clock and request
  input  wire logic       clk_sys,
  input  wire logic [3:0] want,
  // Raw levels: pg0, pg1, oc0, oc1
  output var  logic [3:0] lvl
);
  // Levels move one edge late, like a resampled comparator
  initial lvl = 4'h0;
  always @(posedge clk_sys) lvl <= want;
endmodule // converter_far_side
`default_nettype wire

// ==== sim/regulator_interrupt_masks_test.sv ====
// Self-checking bench for the converter interrupt mask block.
// Assumes the package and the design are compiled first.
`timescale 1ns/1ps
`default_nettype none
module regulator_interrupt_masks_test;
  import irq_mask_pkg::*;
  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [3:0] want = 4'h0;
  logic [3:0] lvl;
  logic [4:0] clr = 5'h00;
  logic       rr_ev = 1'b0;
  logic [3:0] raw;
  logic [3:0] flag;
  logic       rr_flag;
  logic [7:0] open_rdata;
  logic       open_rr_flag;
  int         error_cnt = 0;
  int         n_compared = 0;
  // Per source: level index, mask bit, starts high (valid direction)
  int         li[6] = '{0, 0, 2, 1, 1, 3};
  int         bt[6] = '{3, 2, 0, 7, 6, 4};
  bit         fl[6] = '{0, 1, 0, 0, 1, 0};
  converter_far_side far (.clk_sys(clk_sys), .want(want), .lvl(lvl));
  regulator_interrupt_masks uut (
    .clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .conv0_pg_in(lvl[0]), .conv1_pg_in(lvl[1]),
    .conv0_overcurrent_in(lvl[2]), .conv1_overcurrent_in(lvl[3]),
    .reset_reg_event(rr_ev), .conv0_pg_irq_clr(clr[0]),
    .conv1_pg_irq_clr(clr[1]), .conv0_overcurrent_irq_clr(clr[2]),
    .conv1_overcurrent_irq_clr(clr[3]), .reset_reg_irq_clr(clr[4]),
    .conv0_pg_raw(raw[0]), .conv1_pg_raw(raw[1]),
    .conv0_overcurrent_raw(raw[2]), .conv1_overcurrent_raw(raw[3]),
    .conv0_pg_irq_flag(flag[0]), .conv1_pg_irq_flag(flag[1]),
    .conv0_overcurrent_irq_flag(flag[2]),
    .conv1_overcurrent_irq_flag(flag[3]), .reset_reg_irq_flag(rr_flag));
  // Second copy fused with the gate open, so the reset-reg event can fire
  regulator_interrupt_masks #(.RESET_GATE_OTP(1'b0)) uut_open (
    .clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(open_rdata),
    .conv0_pg_in(lvl[0]), .conv1_pg_in(lvl[1]),
    .conv0_overcurrent_in(lvl[2]), .conv1_overcurrent_in(lvl[3]),
    .reset_reg_event(rr_ev), .conv0_pg_irq_clr(clr[0]),
    .conv1_pg_irq_clr(clr[1]), .conv0_overcurrent_irq_clr(clr[2]),
    .conv1_overcurrent_irq_clr(clr[3]), .reset_reg_irq_clr(clr[4]),
    .conv0_pg_raw(), .conv1_pg_raw(),
    .conv0_overcurrent_raw(), .conv1_overcurrent_raw(),
    .conv0_pg_irq_flag(), .conv1_pg_irq_flag(),
    .conv0_overcurrent_irq_flag(),
    .conv1_overcurrent_irq_flag(), .reset_reg_irq_flag(open_rr_flag));
  // Inputs always move 1 ns after the edge to avoid races
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: byte %h, want %h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: bit %b, want %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc(1);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    cyc(1);
    reg_wr = 1'b0;
  endtask
  // Read data is registered, so it is sampled one edge later
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    cyc(1);
    reg_rd = 1'b1;
    reg_addr = a;
    cyc(1);
    reg_rd = 1'b0;
    cyc(1);
    cmp8(reg_rdata, exp);
  endtask
  // Settle the level, clear all flags, then make one event
  task automatic ev(input int k, input logic [7:0] m);
    wr(ADDR_CONV_MASK, m);
    want[li[k]] = fl[k];
    cyc(3);
    clr = 5'h1F;
    cyc(1);
    clr = 5'h00;
    want[li[k]] = !fl[k];
    cyc(3);
    cmp1(raw[li[k]], !fl[k]);
    cmp1(flag[li[k]], !m[bt[k]]);
    want[li[k]] = 1'b0;
    cyc(3);
  endtask
  task automatic test_done;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial forever #12.5 clk_sys = ~clk_sys;
  // Watchdog: the tests need well under 1000 cycles
  initial begin
    cyc(4000);
    error_cnt++;
    test_done;
  end
  initial begin
    cyc(4);
    rst = 1'b0;
    rd(ADDR_CONV_MASK, CONV_MASK_RESET);
    rd(ADDR_TOP_MASK_TWO, 8'h01);
    cmp8(open_rdata, 8'h00);
    wr(ADDR_TOP_MASK_TWO, 8'hFE);
    rd(ADDR_TOP_MASK_TWO, 8'h01);
    rr_ev = 1'b1;
    cyc(1);
    rr_ev = 1'b0;
    cyc(2);
    cmp1(rr_flag, 1'b0);
    cmp1(open_rr_flag, 1'b1);
    // Event and clear in one cycle: the set must win
    rr_ev = 1'b1;
    clr = 5'h10;
    cyc(1);
    cmp1(open_rr_flag, 1'b1);
    rr_ev = 1'b0;
    cyc(1);
    clr = 5'h00;
    cmp1(open_rr_flag, 1'b0);
    wr(ADDR_CONV_MASK, 8'hFF);
    rd(ADDR_CONV_MASK, 8'hDD);
    wr(8'h30, 8'hFF);
    rd(8'h30, 8'h00);
    $display("test registers done");
    for (int k = 0; k < 6; k++) begin
      ev(k, CONV_MASK_WMASK & ~(8'h01 << bt[k]));
      ev(k, CONV_MASK_WMASK);
    end
    $display("test events done");
    wr(ADDR_CONV_MASK, 8'h00);
    want[2] = 1'b1;
    cyc(3);
    cmp1(flag[2], 1'b1);
    want[2] = 1'b0;
    rst = 1'b1;
    cyc(1);
    rst = 1'b0;
    rd(ADDR_CONV_MASK, CONV_MASK_RESET);
    rd(ADDR_TOP_MASK_TWO, 8'h01);
    cmp8({3'h0, rr_flag, flag}, 8'h00);
    $display("test second reset done");
    test_done;
  end
endmodule // regulator_interrupt_masks_test
`default_nettype wire
